/* File: rtl/vrc_pkg.sv */
// Package with register map, field layout, reset values and timing for the voltage reference block
package vrc_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] LADDER_CTRL_OFS = 4'h0;
  localparam logic [3:0] FIXED_CTRL_OFS = 4'h1;

  // Ladder control field positions
  localparam int unsigned LADDER_EN_BIT = 7;
  localparam int unsigned LADDER_PIN_OE_BIT = 6;
  localparam int unsigned RANGE_SEL_BIT = 5;
  localparam int unsigned SOURCE_SEL_BIT = 4;
  localparam int unsigned LEVEL_MSB = 3;
  localparam int unsigned LEVEL_LSB = 0;
  localparam int unsigned LEVEL_W = 4;

  // Fixed reference control field positions
  localparam int unsigned FIXED_EN_BIT = 7;
  localparam int unsigned FIXED_STABLE_BIT = 6;

  // Reset values
  localparam logic [7:0] LADDER_CTRL_RST = 8'h00;
  localparam logic FIXED_EN_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;

  // Tap expressed in 96ths of the source span, the common multiple of 24 and 32
  localparam int unsigned TAP_W = 7;
  localparam logic [2:0] LOW_RANGE_MULT = 3'h4;
  localparam logic [2:0] HIGH_RANGE_MULT = 3'h3;
  localparam logic [4:0] HIGH_RANGE_BASE = 5'h08;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned SETTLE_TIME_NS = 10000;
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Number of comparators that pick a reference
  localparam int unsigned NUM_COMPARATORS = 2;

endpackage

/* File: rtl/vrc_settle.sv */
// Settling counter that raises a stable flag after an enable has held high long enough
`timescale 1ns/1ns
module vrc_settle #(
  parameter int unsigned SETTLE_CYCLES = vrc_pkg::SETTLE_CYCLES,
  parameter int unsigned CNT_W = (SETTLE_CYCLES < 2) ? 1 : $clog2(SETTLE_CYCLES + 1)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Enable and status
  input wire logic en_i,
  output logic stable_o
);

  localparam logic [CNT_W-1:0] LAST = CNT_W'(SETTLE_CYCLES - 1);

  logic [CNT_W-1:0] cnt_reg;
  logic stable_reg;

  // Counter restarts on any drop of the enable, so a glitchy enable never shows stable early
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_reg <= '0;
    end else if (!en_i) begin
      cnt_reg <= '0;
    end else if (!stable_reg) begin
      cnt_reg <= cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stable_reg <= 1'b0;
    end else if (!en_i) begin
      stable_reg <= 1'b0; // [RULE16]
    end else if (cnt_reg == LAST) begin
      stable_reg <= 1'b1; // [RULE16]
    end
  end

  assign stable_o = stable_reg;

endmodule

/* File: rtl/vrc_top.sv */
// Control and status logic for the resistor-ladder reference and the fixed bandgap reference
//
// Operation
// [RULE1] Two ladder ranges by range bit; 4-bit level picks one of 16 taps.
// [RULE2] Range 1 taps level/24 of span; range 0 taps (8+level)/32.
// [RULE3] Source bit 1 feeds ladder from reference pins; 0 from supply to ground.
// [RULE4] Software clamps output to ground: enable off, low range, level zero.
// [RULE5] Pin-output bit drives ladder on pin, killing digital buffer and detector.
// [RULE6] Digital read of the pin returns zero while it outputs the reference.
// [RULE7] Wake from sleep leaves ladder control register contents untouched.
// [RULE8] Software should disable the ladder before sleep to save current.
// [RULE9] Reset disables both references, frees pin, high range, level cleared.
// [RULE10] Fixed reference powered by its bit or oscillator, voltage detect, brown-out.
// [RULE11] Read-only stable bit is 1 once fixed reference settled, else 0.
// [RULE12] Software waits settling delay or polls stable bit before use.
// [RULE13] Ladder register: enable 7, pin out 6, range 5, source 4, level 3-0.
// [RULE14] Fixed register: enable bit 7 RW, stable bit 6 RO, bits 5-0 zero.
// [RULE15] Comparator select 1 routes ladder, 0 routes fixed reference.
// [RULE16] Stable flag clears with effective enable low; sets after settling count.
`timescale 1ns/1ns
module vrc_top #(
  parameter int unsigned SETTLE_CYCLES = vrc_pkg::SETTLE_CYCLES,
  parameter int unsigned NUM_COMP = vrc_pkg::NUM_COMPARATORS
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Register port
  input wire logic [vrc_pkg::ADDR_W-1:0] addr_i,
  input wire logic [vrc_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [vrc_pkg::DATA_W-1:0] rdata_o,
  // Other users of the fixed reference
  input wire logic internal_fast_oscillator_en_i,
  input wire logic voltage_detect_unit_en_i,
  input wire logic brownout_reset_function_en_i,
  // Sleep state, has no effect on stored control
  input wire logic sleep_i,
  // Ladder analogue controls
  output logic ladder_power_o,
  output logic range_select_o,
  output logic ladder_source_select_o,
  output logic [vrc_pkg::LEVEL_W-1:0] ladder_level_o,
  output logic [vrc_pkg::TAP_W-1:0] ladder_tap_96ths_o,
  output logic ladder_neg_ref_zero_o,
  // Fixed reference analogue controls
  output logic fixed_ref_power_o,
  output logic fixed_ref_stable_o,
  // Reference pin
  input wire logic port_a_direction_i,
  input wire logic pin_latch_i,
  input wire logic pin_i,
  output logic pin_o,
  output logic pin_oe_o,
  output logic pin_input_detect_en_o,
  output logic ladder_reference_output_o,
  output logic pin_read_o,
  // Comparator reference routing
  input wire logic [NUM_COMP-1:0] comparator_ref_select_i,
  output logic [NUM_COMP-1:0] comparator_ref_ladder_o,
  output logic [NUM_COMP-1:0] comparator_ref_fixed_o
);

  logic [7:0] ladder_ctrl_reg;
  logic fixed_en_reg;
  logic [vrc_pkg::DATA_W-1:0] rdata_reg;
  logic [vrc_pkg::DATA_W-1:0] rdata_next;
  logic [vrc_pkg::TAP_W-1:0] tap_reg;
  logic [vrc_pkg::TAP_W-1:0] tap_next;
  logic pin_read_reg;
  logic fixed_eff_en;
  logic stable;
  logic pin_override;
  logic [vrc_pkg::LEVEL_W-1:0] level;

  assign level = ladder_ctrl_reg[vrc_pkg::LEVEL_MSB:vrc_pkg::LEVEL_LSB];

  // Ladder control register; sleep_i is deliberately not a term here
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ladder_ctrl_reg <= vrc_pkg::LADDER_CTRL_RST; // [RULE9]
    end else if (wr_i && addr_i == vrc_pkg::LADDER_CTRL_OFS) begin
      ladder_ctrl_reg <= wdata_i; // [RULE13] [RULE7]
    end
  end

  // Fixed reference enable, only bit 7 is storage
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fixed_en_reg <= vrc_pkg::FIXED_EN_RST; // [RULE9]
    end else if (wr_i && addr_i == vrc_pkg::FIXED_CTRL_OFS) begin
      fixed_en_reg <= wdata_i[vrc_pkg::FIXED_EN_BIT]; // [RULE14]
    end
  end

  // Clearing the bit cannot switch the bandgap off while another user needs it
  assign fixed_eff_en = fixed_en_reg | internal_fast_oscillator_en_i |
                        voltage_detect_unit_en_i | brownout_reset_function_en_i; // [RULE10]

  vrc_settle #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_settle (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .en_i(fixed_eff_en),
    .stable_o(stable)
  );

  // Read mux; data appear only in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (rd_i) begin
      case (addr_i)
        vrc_pkg::LADDER_CTRL_OFS: begin
          rdata_next = ladder_ctrl_reg; // [RULE13]
        end
        vrc_pkg::FIXED_CTRL_OFS: begin
          rdata_next[vrc_pkg::FIXED_EN_BIT] = fixed_en_reg; // [RULE14]
          rdata_next[vrc_pkg::FIXED_STABLE_BIT] = stable; // [RULE11]
        end
        default: begin
          rdata_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= vrc_pkg::RDATA_RST;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Tap position in 96ths: level*4 for low range, (8+level)*3 for high range
  always_comb begin
    tap_next = '0;
    if (ladder_ctrl_reg[vrc_pkg::RANGE_SEL_BIT]) begin
      tap_next = vrc_pkg::TAP_W'({3'h0, level} * vrc_pkg::LOW_RANGE_MULT); // [RULE2] [RULE1]
    end else begin
      // Widened to the tap width first, since (8+15)*3 overflows the 5-bit base
      tap_next = ({2'h0, vrc_pkg::HIGH_RANGE_BASE} + {3'h0, level}) *
                 {4'h0, vrc_pkg::HIGH_RANGE_MULT}; // [RULE2] [RULE1]
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tap_reg <= '0;
    end else begin
      tap_reg <= tap_next;
    end
  end

  // Pin override beats the direction bit
  assign pin_override = ladder_ctrl_reg[vrc_pkg::LADDER_PIN_OE_BIT]; // [RULE5]

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_read_reg <= 1'b0;
    end else begin
      pin_read_reg <= pin_override ? 1'b0 : pin_i; // [RULE6]
    end
  end

  // Comparator reference routing, one select per comparator
  for (genvar g = 0; g < NUM_COMP; g++) begin : g_comp
    assign comparator_ref_ladder_o[g] = comparator_ref_select_i[g]; // [RULE15]
    assign comparator_ref_fixed_o[g] = !comparator_ref_select_i[g]; // [RULE15]
  end

  // Outputs
  assign rdata_o = rdata_reg;
  assign ladder_power_o = ladder_ctrl_reg[vrc_pkg::LADDER_EN_BIT];
  assign range_select_o = ladder_ctrl_reg[vrc_pkg::RANGE_SEL_BIT]; // [RULE1]
  assign ladder_source_select_o = ladder_ctrl_reg[vrc_pkg::SOURCE_SEL_BIT]; // [RULE3]
  assign ladder_neg_ref_zero_o = !ladder_ctrl_reg[vrc_pkg::SOURCE_SEL_BIT]; // [RULE3]
  assign ladder_level_o = level;
  assign ladder_tap_96ths_o = tap_reg;
  assign fixed_ref_power_o = fixed_eff_en; // [RULE10]
  assign fixed_ref_stable_o = stable; // [RULE11]
  assign pin_o = pin_latch_i;
  assign pin_oe_o = !pin_override && !port_a_direction_i; // [RULE5]
  assign pin_input_detect_en_o = !pin_override; // [RULE5]
  assign ladder_reference_output_o = pin_override; // [RULE5]
  assign pin_read_o = pin_read_reg;

endmodule

/* File: dv/vrc_props.sv */
// Port-level checks for the voltage reference control block
`timescale 1ns/1ns
module vrc_props #(
  parameter int unsigned SETTLE_CYCLES = 4
) (
  // Clock, reset and register port
  input logic clk_i,
  input logic nrst_i,
  input logic [3:0] addr_i,
  input logic [7:0] wdata_i,
  input logic wr_i,
  input logic rd_i,
  input logic [7:0] rdata_o,
  // Ladder and fixed reference
  input logic range_select_o,
  input logic [3:0] ladder_level_o,
  input logic [6:0] ladder_tap_96ths_o,
  input logic fixed_ref_power_o,
  input logic fixed_ref_stable_o,
  // Reference pin
  input logic pin_input_detect_en_o,
  input logic ladder_reference_output_o,
  input logic pin_read_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  // Edges seen with the fixed reference powered, saturating at the settle count
  logic [7:0] run_cnt;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) run_cnt <= 8'h00;
    else if (!fixed_ref_power_o) run_cnt <= 8'h00;
    else if (run_cnt < SETTLE_CYCLES) run_cnt <= run_cnt + 8'h01;
  end
  property p_tap;
    $past(nrst_i) |-> ladder_tap_96ths_o == ($past(range_select_o) ?
      $past(ladder_level_o) * 4 : ($past(ladder_level_o) + 8) * 3);
  endproperty
  a_tap: assert property (p_tap) else $error("tap wrong");
  property p_wr;
    wr_i && addr_i == 4'h0 |=> {ladder_reference_output_o, range_select_o,
      ladder_level_o} == {$past(wdata_i[6:5]), $past(wdata_i[3:0])};
  endproperty
  a_wr: assert property (p_wr) else $error("write lost");
  property p_idle;
    !rd_i |=> rdata_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_rdf;
    rd_i && addr_i == 4'h1 |=> rdata_o[6:0] == {$past(fixed_ref_stable_o), 6'h00};
  endproperty
  a_rdf: assert property (p_rdf) else $error("fixed status read wrong");
  property p_clr;
    !fixed_ref_power_o |=> !fixed_ref_stable_o;
  endproperty
  a_clr: assert property (p_clr) else $error("stable not cleared");
  property p_set;
    fixed_ref_stable_o == (run_cnt >= SETTLE_CYCLES);
  endproperty
  a_set: assert property (p_set) else $error("stable timing wrong");
  property p_pin;
    ladder_reference_output_o |-> !pin_input_detect_en_o;
  endproperty
  a_pin: assert property (p_pin) else $error("detector not off");
  property p_prd;
    $past(nrst_i) && $past(ladder_reference_output_o) |-> !pin_read_o;
  endproperty
  a_prd: assert property (p_prd) else $error("pin read not zero");
endmodule
bind vrc_top vrc_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.clk_i, .nrst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .range_select_o, .ladder_level_o, .ladder_tap_96ths_o,
  .fixed_ref_power_o, .fixed_ref_stable_o, .pin_input_detect_en_o,
  .ladder_reference_output_o, .pin_read_o);

/* File: dv/testbench.sv */
// Self-checking bench for the voltage reference control block
`timescale 1ns/1ns
module testbench;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sleep_i = 1'b0;
  logic [2:0] usr = 3'h0;
  logic dir = 1'b1;
  logic lat = 1'b0;
  logic pin = 1'b0;
  logic [1:0] cs = 2'h0;
  logic [15:0] seed = 16'h3d80;
  wire [7:0] rdat;
  wire [6:0] tap;
  wire [3:0] lvl;
  wire pwr, rng, src, nz, fp, fst, po, poe, pdet, pref, prd;
  wire [1:0] cl, cf;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  vrc_top #(.SETTLE_CYCLES(4)) DUT (.clk_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o(rdat), .internal_fast_oscillator_en_i(usr[0]), .voltage_detect_unit_en_i(usr[1]),
    .brownout_reset_function_en_i(usr[2]), .sleep_i, .ladder_power_o(pwr),
    .range_select_o(rng), .ladder_source_select_o(src), .ladder_level_o(lvl),
    .ladder_tap_96ths_o(tap), .ladder_neg_ref_zero_o(nz), .fixed_ref_power_o(fp),
    .fixed_ref_stable_o(fst), .port_a_direction_i(dir), .pin_latch_i(lat), .pin_i(pin),
    .pin_o(po), .pin_oe_o(poe), .pin_input_detect_en_o(pdet),
    .ladder_reference_output_o(pref), .pin_read_o(prd), .comparator_ref_select_i(cs),
    .comparator_ref_ladder_o(cl), .comparator_ref_fixed_o(cf));
  always #50 clk_i = ~clk_i;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [7:0] tap_exp(input logic [7:0] d);
    return d[5] ? 8'(d[3:0] * 4) : 8'((d[3:0] + 8) * 3);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(rdat, exp);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      finish_test();
    end
  end
  initial begin
    logic [7:0] d;
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(4'h0, 8'h00);
    rd(4'h1, 8'h00);
    for (int i = 0; i < 28; i++) begin
      seed = lfsr(seed);
      d = i == 0 ? 8'h2f : i == 1 ? 8'h0f : i == 2 ? 8'hff : i == 3 ? 8'h20 : seed[7:0];
      @(posedge clk_i);
      {dir, lat, pin, sleep_i, cs} <= seed[13:8];
      wr(4'h0, d);
      rd(4'h0, d);
      chk(tap, tap_exp(d));
      chk({src, nz, pwr}, {d[4], ~d[4], d[7]});
      chk({pdet, poe, prd, po}, {~d[6], ~d[6] & ~dir, ~d[6] & pin, lat});
      chk({cl, cf}, {cs, ~cs});
    end
    // Software turns the ladder off before sleeping; contents must survive
    wr(4'h0, 8'h00);
    sleep_i <= 1'b1;
    rd(4'h0, 8'h00);
    sleep_i <= 1'b0;
    wr(4'h0, d);
    wr(4'h1, 8'hff);
    rd(4'h1, 8'h80);
    repeat (4) @(posedge clk_i);
    rd(4'h1, 8'hc0);
    wr(4'h1, 8'h00);
    rd(4'h1, 8'h00);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_i);
      usr <= 3'h1 << k;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      chk({fp, fst}, 8'h03);
    end
    @(posedge clk_i);
    usr <= 3'h0;
    wr(4'h7, 8'hff);
    rd(4'h7, 8'h00);
    rd(4'h0, d);
    @(posedge clk_i);
    nrst_i <= 1'b0;
    @(negedge clk_i);
    chk({pwr, pref, rng, lvl, fst}, 8'h00);
    @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(4'h0, 8'h00);
    finish_test();
  end
endmodule
